// ===== tcms_pkg.sv
package tcms_pkg;
   // Array geometry: 4 streams of 32 channels
   localparam int STREAM_W = 2;
   localparam int CHAN_W = 5;
   localparam int LOC_W = STREAM_W + CHAN_W;
   localparam int NUM_LOC = 128;
   localparam int NUM_STREAMS = 4;
   localparam int BYTE_W = 8;
   // High-half word fields
   localparam int HI_SRC_BIT = 2;
   localparam int HI_OE_BIT = 0;
   localparam logic [7:0] HI_STORED_MASK = 8'h05;
   // Low-half word fields
   localparam int LO_STREAM_MSB = 6;
   localparam int LO_STREAM_LSB = 5;
   localparam int LO_CHAN_MSB = 4;
   localparam int LO_CHAN_LSB = 0;
   // Processor-mode bit position in the control byte
   localparam int CTRL_PMODE_BIT = 6;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [6:0] ZERO_LOC = 7'h00;

   // Processor access to connection memory
   typedef enum logic [1:0] {
      TCMS_SEL_LOW = 2'b00,
      TCMS_SEL_HIGH = 2'b01,
      TCMS_SEL_NONE = 2'b10
   } tcms_sel_type;

   typedef struct packed {
      logic wr;
      tcms_sel_type sel;
      logic [6:0] loc;
      logic [7:0] data;
   } tcms_cpu_req_type;

   // One output slot: byte and driver enable for a location
   typedef struct packed {
      logic [7:0] data;
      logic drive;
      logic [6:0] loc;
   } tcms_slot_type;
endpackage

// ===== tcms_route.sv
`timescale 1ns/1ps
// Decides source byte and driver enable for one connection word pair
module tcms_route (
   input wire logic [7:0] conn_mem_high, // High-half word of slot
   input wire logic [7:0] conn_mem_low, // Low-half word of slot
   input wire logic processor_mode_force, // Control bit 6
   input wire logic global_output_drive_en, // Global drive pin
   output logic literal, // Send low-half byte as is
   output logic [6:0] rx_index, // Received-data memory index
   output logic drive // Driver enable
);
   logic src_bit;
   logic oe_bit;

   // Forced mode reads both bits as one
   always_comb begin
      src_bit = conn_mem_high[tcms_pkg::HI_SRC_BIT]
         | processor_mode_force;
      oe_bit = conn_mem_high[tcms_pkg::HI_OE_BIT]
         | processor_mode_force;
      literal = src_bit;
      // Stream above channel gives the 128-entry index
      rx_index = {
         conn_mem_low[tcms_pkg::LO_STREAM_MSB:tcms_pkg::LO_STREAM_LSB],
         conn_mem_low[tcms_pkg::LO_CHAN_MSB:tcms_pkg::LO_CHAN_LSB]
      };
      drive = global_output_drive_en & oe_bit;
   end
endmodule // tcms_route

// ===== tcms_output_select.sv
`timescale 1ns/1ps
// Contract
// - High-half bits 7..3 have no storage and read back as zero.
// - Source bit 1: transmit low-half byte unchanged on that channel.
// - Source bit 0: low-half word addresses received-data memory byte.
// - Per-channel enable acts only with drive pin high, mode bit clear.
// - Enable 1 drives the timeslot; 0 leaves it high-impedance.
// - Low-half bits 6..5 give source stream, bit 6 most significant.
// - Low-half bits 4..0 give source channel, bit 4 most significant.
// - Literal or processor mode sends all eight low-half bits.
// - Drive pin low holds every output high-impedance.
// - Processor mode acts as if source and enable bits were one.
module tcms_output_select (
   input wire logic mclk, // 250 MHz clock
   input wire logic rst_b, // Synchronous reset, low active
   input wire logic clk_en, // Freezes all state when low
   input wire logic global_output_drive_en, // Global drive pin
   input wire logic processor_mode_force, // Control bit 6
   input wire tcms_pkg::tcms_cpu_req_type cpu_req, // Processor access
   input wire logic cpu_req_valid, // Access strobe
   input wire logic [6:0] slot_loc, // Current output stream and channel
   input wire logic slot_valid, // Slot step strobe
   input wire logic rx_wr, // Received byte write strobe
   input wire logic [6:0] rx_wr_loc, // Received byte position
   input wire logic [7:0] rx_wr_data, // Received byte
   output logic [7:0] cpu_rd_data, // Read data
   output logic cpu_rd_valid, // Read data valid pulse
   output tcms_pkg::tcms_slot_type slot_out, // Output byte and enable
   output logic slot_out_valid // Output slot valid pulse
);
   // Hidden high bits are simply not stored
   logic [1:0] high_mem [tcms_pkg::NUM_LOC];
   logic [7:0] low_mem [tcms_pkg::NUM_LOC];
   logic [7:0] rx_mem [tcms_pkg::NUM_LOC];
   logic [7:0] cur_high;
   logic [7:0] cur_low;
   logic literal;
   logic drive;
   logic [6:0] rx_index;

   function automatic logic [7:0] high_word(input logic [1:0] s);
      high_word = tcms_pkg::ZERO_BYTE;
      high_word[tcms_pkg::HI_SRC_BIT] = s[1];
      high_word[tcms_pkg::HI_OE_BIT] = s[0];
   endfunction

   // Word pair for the current timeslot
   always_comb begin
      cur_high = high_word(high_mem[slot_loc]);
      cur_low = low_mem[slot_loc];
   end

   tcms_route u_route (
      .conn_mem_high(cur_high),
      .conn_mem_low(cur_low),
      .processor_mode_force(processor_mode_force),
      .global_output_drive_en(global_output_drive_en),
      .literal(literal),
      .rx_index(rx_index),
      .drive(drive)
   );

   // Connection memory writes; contents are undefined until programmed
   always_ff @(posedge mclk) begin
      if (clk_en && cpu_req_valid && cpu_req.wr) begin
         if (cpu_req.sel == tcms_pkg::TCMS_SEL_HIGH) begin
            high_mem[cpu_req.loc] <=
               {cpu_req.data[tcms_pkg::HI_SRC_BIT],
                cpu_req.data[tcms_pkg::HI_OE_BIT]};
         end
         if (cpu_req.sel == tcms_pkg::TCMS_SEL_LOW) begin
            low_mem[cpu_req.loc] <= cpu_req.data;
         end
      end
   end

   // Received-data memory fill
   always_ff @(posedge mclk) begin
      if (clk_en && rx_wr) begin
         rx_mem[rx_wr_loc] <= rx_wr_data;
      end
   end

   // Processor read path, one cycle latency
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cpu_rd_data <= tcms_pkg::ZERO_BYTE;
         cpu_rd_valid <= 1'b0;
      end else if (clk_en) begin
         cpu_rd_valid <= cpu_req_valid && !cpu_req.wr;
         case (cpu_req.sel)
            tcms_pkg::TCMS_SEL_HIGH: begin
               cpu_rd_data <= high_word(high_mem[cpu_req.loc]);
            end
            tcms_pkg::TCMS_SEL_LOW: begin
               cpu_rd_data <= low_mem[cpu_req.loc];
            end
            default: begin
               cpu_rd_data <= tcms_pkg::ZERO_BYTE;
            end
         endcase
      end
   end

   // Read-path checks; a low-word read must not trip the hidden-bit check
   chk_high_read: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && cpu_req_valid && !cpu_req.wr
       && cpu_req.sel == tcms_pkg::TCMS_SEL_HIGH)
      |=> (cpu_rd_data & ~tcms_pkg::HI_STORED_MASK) == tcms_pkg::ZERO_BYTE)
      else $error("unstored high bits nonzero");

   chk_none_read: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && cpu_req_valid && !cpu_req.wr
       && cpu_req.sel == tcms_pkg::TCMS_SEL_NONE)
      |=> cpu_rd_data == tcms_pkg::ZERO_BYTE)
      else $error("unselected read not zero");

   chk_rd_pulse: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en |=> cpu_rd_valid == $past(cpu_req_valid && !cpu_req.wr))
      else $error("read valid pulse wrong");

   // Output stage; the byte stays raw when not driven, drive gates the pin
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         slot_out <= '0;
         slot_out_valid <= 1'b0;
      end else if (clk_en) begin
         slot_out_valid <= slot_valid;
         if (slot_valid) begin
            slot_out.loc <= slot_loc;
            slot_out.drive <= drive;
            if (literal) begin
               slot_out.data <= cur_low;
            end else begin
               slot_out.data <= rx_mem[rx_index];
            end
         end
      end
   end

   // Checks on the output stage
   chk_pin_low_quiet: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && !global_output_drive_en)
      |=> !slot_out.drive)
      else $error("output driven while drive pin low");

   chk_force_drive: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && global_output_drive_en
       && processor_mode_force) |=> slot_out.drive)
      else $error("processor mode did not drive");

   chk_force_literal: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && processor_mode_force)
      |=> slot_out.data == $past(cur_low))
      else $error("processor mode byte wrong");

   chk_oe_follow: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && global_output_drive_en
       && !processor_mode_force)
      |=> slot_out.drive == $past(cur_high[tcms_pkg::HI_OE_BIT]))
      else $error("enable bit not followed");

   chk_oe_zero: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && !processor_mode_force
       && !cur_high[tcms_pkg::HI_OE_BIT]) |=> !slot_out.drive)
      else $error("disabled slot driven");

   chk_oe_one: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && global_output_drive_en
       && !processor_mode_force && cur_high[tcms_pkg::HI_OE_BIT])
      |=> slot_out.drive)
      else $error("enabled slot not driven");

   chk_literal_byte: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && cur_high[tcms_pkg::HI_SRC_BIT])
      |=> slot_out.data == $past(cur_low))
      else $error("literal byte wrong");

   chk_switch_byte: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid && !literal && !rx_wr)
      |=> slot_out.data == $past(rx_mem[rx_index]))
      else $error("switched byte wrong");

   // Index fields are held against the location geometry, not the route
   chk_index_form: assert property (
      @(posedge mclk) disable iff (!rst_b)
      rx_index[tcms_pkg::LOC_W-1:tcms_pkg::CHAN_W]
         == cur_low[tcms_pkg::LO_STREAM_MSB:tcms_pkg::LO_STREAM_LSB]
      && rx_index[tcms_pkg::CHAN_W-1:0]
         == cur_low[tcms_pkg::LO_CHAN_MSB:tcms_pkg::LO_CHAN_LSB])
      else $error("index order wrong");

   chk_slot_loc: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && slot_valid) |=> slot_out.loc == $past(slot_loc))
      else $error("slot location wrong");

   chk_slot_pulse: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en |=> slot_out_valid == $past(slot_valid))
      else $error("slot valid pulse wrong");

   // Between timeslots the serialiser relies on byte and enable staying put
   chk_slot_stands: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !(clk_en && slot_valid) |=> $stable(slot_out))
      else $error("slot output moved without a request");

   chk_hold_frozen: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !clk_en |=> $stable(slot_out_valid) && $stable(cpu_rd_valid)
         && $stable(cpu_rd_data))
      else $error("state moved with clock enable low");

   // No disable here, since reset itself is what is checked
   chk_reset_quiet: assert property (
      @(posedge mclk)
      !rst_b |=> slot_out == '0 && !slot_out_valid && !cpu_rd_valid
         && cpu_rd_data == tcms_pkg::ZERO_BYTE)
      else $error("outputs not cleared by reset");
endmodule // tcms_output_select

// ===== tcms_far_model.sv
`timescale 1ns/1ps
// Far-side streams: fill every received position once, byte = {loc, 1}
module tcms_far_model (
   input wire logic mclk, // Clock
   input wire logic rst_b, // Sync reset, low active
   output logic rx_wr, // Received byte strobe
   output logic [6:0] rx_wr_loc, // Received position
   output logic [7:0] rx_wr_data, // Received byte
   output logic done // All positions filled
);
   logic [7:0] cnt;
   // One byte a cycle; data toggles once idle so stale bytes never match
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt <= 8'h00;
         rx_wr <= 1'b0;
         rx_wr_loc <= 7'h00;
         rx_wr_data <= 8'h00;
         done <= 1'b0;
      end else if (cnt[7]) begin
         rx_wr <= 1'b0;
         rx_wr_data <= ~rx_wr_data;
         done <= 1'b1;
      end else begin
         rx_wr <= 1'b1;
         rx_wr_loc <= cnt[6:0];
         rx_wr_data <= {cnt[6:0], 1'b1};
         cnt <= cnt + 8'h01;
      end
   end
endmodule // tcms_far_model

// ===== tcms_output_select_tb_top.sv
`timescale 1ns/1ps
module tcms_output_select_tb_top;
   localparam tcms_pkg::tcms_sel_type HI = tcms_pkg::TCMS_SEL_HIGH;
   localparam tcms_pkg::tcms_sel_type LO = tcms_pkg::TCMS_SEL_LOW;
   localparam tcms_pkg::tcms_sel_type NO = tcms_pkg::TCMS_SEL_NONE;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic drive_pin = 1'b0;
   logic en = 1'b1;
   logic pm = 1'b0;
   tcms_pkg::tcms_cpu_req_type req = '0;
   logic req_v = 1'b0;
   logic [6:0] sl = 7'h00;
   logic sv = 1'b0;
   logic rx_wr, done, rd_v, so_v;
   logic [6:0] rx_loc;
   logic [7:0] rx_d, rd_d;
   tcms_pkg::tcms_slot_type so;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #2 mclk = ~mclk;
   tcms_far_model far (.mclk(mclk), .rst_b(rst_b), .rx_wr(rx_wr),
      .rx_wr_loc(rx_loc), .rx_wr_data(rx_d), .done(done));
   tcms_output_select dut (.mclk(mclk), .rst_b(rst_b), .clk_en(en),
      .global_output_drive_en(drive_pin), .processor_mode_force(pm),
      .cpu_req(req), .cpu_req_valid(req_v), .slot_loc(sl),
      .slot_valid(sv), .rx_wr(rx_wr), .rx_wr_loc(rx_loc),
      .rx_wr_data(rx_d), .cpu_rd_data(rd_d), .cpu_rd_valid(rd_v),
      .slot_out(so), .slot_out_valid(so_v));
   task automatic chk(input logic [16:0] g, input logic [16:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Access held one edge; a read answer is looked at in the next cycle
   task automatic cpu(input logic w, input tcms_pkg::tcms_sel_type s,
         input logic [6:0] l, input logic [7:0] d);
      @(posedge mclk);
      req <= '{w, s, l, d};
      req_v <= 1'b1;
      @(posedge mclk);
      req_v <= 1'b0;
      #1;
      if (!w) chk({8'h00, rd_v, rd_d}, {8'h00, 1'b1, d});
   endtask
   // Data only matters when the timeslot is driven
   task automatic slot(input logic [6:0] l, input logic r, logic [7:0] d);
      @(posedge mclk);
      sl <= l;
      sv <= 1'b1;
      @(posedge mclk);
      sv <= 1'b0;
      #1;
      if (r) chk({so_v, so}, {1'b1, d, 1'b1, l});
      else chk({8'h00, so_v, so.drive, so.loc}, {8'h00, 2'b10, l});
   endtask
   task automatic t_regs;
      cpu(1, HI, 7'h05, 8'hFF);
      cpu(0, HI, 7'h05, 8'h05);
      cpu(1, HI, 7'h06, 8'hFA);
      cpu(0, HI, 7'h06, 8'h00);
      cpu(1, LO, 7'h05, 8'hAB);
      cpu(1, LO, 7'h06, 8'h3C);
      cpu(0, LO, 7'h05, 8'hAB);
      cpu(0, NO, 7'h05, 8'h00);
      $display("register test done");
   endtask
   task automatic t_lit;
      slot(7'h05, 1'b0, 8'h00);
      // Park every other location disabled before the pin goes high
      for (int i = 0; i < tcms_pkg::NUM_LOC; i++) begin
         if (i != 5 && i != 6) cpu(1, HI, i[6:0], 8'h00);
      end
      @(posedge mclk);
      drive_pin <= 1'b1;
      slot(7'h05, 1'b1, 8'hAB);
      slot(7'h06, 1'b0, 8'h00);
      $display("literal test done");
   endtask
   task automatic t_sw;
      cpu(1, HI, 7'h07, 8'h01);
      cpu(1, LO, 7'h07, 8'hD3);
      slot(7'h07, 1'b1, 8'hA7);
      cpu(1, LO, 7'h07, 8'h2C);
      slot(7'h07, 1'b1, 8'h59);
      $display("switch test done");
   endtask
   // A slot offered with the enable low must leave the last slot standing
   task automatic t_hold;
      @(posedge mclk);
      en <= 1'b0;
      sl <= 7'h05;
      sv <= 1'b1;
      @(posedge mclk);
      sv <= 1'b0;
      #1;
      chk({so_v, so}, {1'b0, 8'h59, 1'b1, 7'h07});
      @(posedge mclk);
      en <= 1'b1;
      $display("clock enable test done");
   endtask
   task automatic t_pm;
      @(posedge mclk);
      pm <= 1'b1;
      slot(7'h06, 1'b1, 8'h3C);
      cpu(1, LO, 7'h07, 8'hD3);
      slot(7'h07, 1'b1, 8'hD3);
      @(posedge mclk);
      drive_pin <= 1'b0;
      slot(7'h06, 1'b0, 8'h00);
      $display("processor mode test done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         final_report;
      end
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      // A far side that never finishes is caught by the hang guard
      while (!done) @(posedge mclk);
      t_regs;
      t_lit;
      t_sw;
      t_hold;
      t_pm;
      final_report;
   end
endmodule // tcms_output_select_tb_top
